/* File: include/ntresp_pkg.sv */
// Notes on behaviour
// (R1) REQA or WUPA is answered with answer-to-request 00 44h, low byte 44h first.
// (R2) Successful level-2 select is answered with select-acknowledge byte 00h.
// (R3) Answer-to-request bits 7 and 8 always code the UID size.
// (R4) Version query 60h with CRC returns eight bytes of product information.
// (R5) Version bytes: header 00h, five id codes, size code, protocol 03h.
// (R6) Size code holds n in upper seven bits; low bit marks in-between size.
// (R7) Size code is 13h for 888-byte memory, 15h for 1912-byte memory.
// (R8) Signature read 3Ch with address 00h returns a 32-byte signature.
// (R9) The signature is fixed at manufacture and no command changes it.
// (R10) Password command 1Bh with four bytes returns the two-byte acknowledge value on match.
// (R11) Protected memory is reachable only after a successful password in this session.
// (R12) Protect start page marks the first protected page; all higher pages too.
// (R13) Protect level bit selects write-only or read-and-write protection.
// (R14) Attempt limit field above zero counts failures; zero disables limiting.
// (R15) At two to the field failures, protected access is refused for good.
// (R16) No response to these commands before frame delay n=9; reader times out at 5 ms. Code holds off until wait_q reaches FDT_CYC = 10, 10 ns a clock.
// (R17) Wrong password or invalid argument answers negative code 0h.
// (R18) Password attempt after the limit answers negative code 4h.
// (R19) Parity or CRC error answers negative code 1h.
// (R20) Halt or field loss clears the authenticated state.
package ntresp_pkg;
    localparam logic [7:0]  CMD_REQA      = 8'h26;
    localparam logic [7:0]  CMD_WUPA      = 8'h52;
    localparam logic [7:0]  CMD_SEL_CL2   = 8'h95;
    localparam logic [7:0]  CMD_VERSION   = 8'h60;
    localparam logic [7:0]  CMD_SIG       = 8'h3C;
    localparam logic [7:0]  CMD_PWD       = 8'h1B;
    localparam logic [7:0]  SIG_ADDR      = 8'h00;
    localparam logic [15:0] ATQA_VALUE    = 16'h0044;
    localparam logic [7:0]  SAK_VALUE     = 8'h00;
    localparam logic [7:0]  VER_HEADER    = 8'h00;
    localparam logic [7:0]  VER_PROTOCOL  = 8'h03;
    localparam logic [7:0]  SIZE_CODE_1K  = 8'h13;
    localparam logic [7:0]  SIZE_CODE_2K  = 8'h15;
    localparam logic [3:0]  NAK_INVALID   = 4'h0;
    localparam logic [3:0]  NAK_CRC       = 4'h1;
    localparam logic [3:0]  NAK_LIMIT     = 4'h4;
    localparam int          VER_LEN       = 8;
    localparam int          SIG_LEN       = 32;
    localparam int          AUTH_ACK_VALUE_LEN      = 2;
    localparam int          ATQA_LEN      = 2;
    // Frame delay n=9: (n*128+84)/fc with fc = 13.56 MHz, rounded up in us; FDT_CYC counts that value as ns
    localparam int          FDT_N         = 9;
    localparam int          FDT_NS        = ((FDT_N * 128 + 84) * 1000 + 13559) / 13560;
    localparam int          CLK_NS        = 10;
    localparam int          FDT_CYC       = (FDT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  RST_PROT_START = 8'hFF;
    localparam logic [2:0]  RST_LIMIT      = 3'h0;
endpackage

/* File: rtl/ntresp_sig_rom.sv */
`timescale 1ns/100ps
// Read-only signature store; contents fixed by parameter, no write path
module ntresp_sig_rom #(
    parameter int             DEPTH = 32,
    parameter logic [255:0]   INIT  = 256'h0
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [4:0]   addr,
    output logic      [7:0]   rdata
);
    // Elaboration-time refusal of a depth the byte select cannot serve
    if (DEPTH != 32) begin : g_bad_depth
        $error("signature store must be 32 bytes");
    end

    // Registered read; no write port at all keeps the contents immutable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= INIT[{addr, 3'b000} +: 8]; // R9
        end
    end
endmodule

/* File: rtl/ntresp_core.sv */
`timescale 1ns/100ps
// Contactless command responder: activation answers, version, signature, password
module ntresp_core #(
    parameter logic [7:0]   VENDOR_ID  = 8'hA5, // Arbitrary identity value
    parameter logic [7:0]   PROD_TYPE  = 8'h5A, // Arbitrary identity value
    parameter logic [7:0]   PROD_SUB   = 8'h3C, // Arbitrary identity value
    parameter logic [7:0]   VER_MAJOR  = 8'h11, // Arbitrary identity value
    parameter logic [7:0]   VER_MINOR  = 8'h22, // Arbitrary identity value
    parameter bit           LARGE_MEM  = 1'b0,
    parameter logic [255:0] SIGNATURE  = 256'h0
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_last,
    input  wire logic        rx_crc_err,
    input  wire logic        sel_cl2_ok,
    input  wire logic        halt,
    input  wire logic        field_lost,
    input  wire logic [31:0] password,
    input  wire logic [15:0] auth_ack_value,
    input  wire logic [7:0]  protect_start_page,
    input  wire logic        protect_level_bit,
    input  wire logic [2:0]  attempt_limit_field,
    input  wire logic [7:0]  page_addr,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_byte,
    output logic             tx_last,
    output logic             tx_nak,
    output logic             authenticated,
    output logic             locked_out,
    output logic             page_protected,
    output logic             read_allowed,
    output logic             write_allowed,
    output logic [7:0]       fail_count
);
    typedef enum logic [4:0] {
        NR_IDLE  = 5'b00001,
        NR_RECV  = 5'b00010,
        NR_WAIT  = 5'b00100,
        NR_SEND  = 5'b01000,
        NR_DRAIN = 5'b10000
    } ntresp_state_t;

    typedef enum logic [2:0] {
        AN_ATQA, AN_SAK, AN_VER, AN_SIG, AN_AUTH_ACK_VALUE, AN_NAK
    } ntresp_ans_t;

    localparam logic [7:0] SIZE_CODE = LARGE_MEM ? ntresp_pkg::SIZE_CODE_2K : ntresp_pkg::SIZE_CODE_1K;

    ntresp_state_t state_q;
    ntresp_ans_t   ans_q;
    logic [7:0]    cmd_q;
    logic [2:0]    arg_cnt_q;
    logic [31:0]   arg_q;
    logic [3:0]    nak_q;
    logic [5:0]    idx_q;
    logic [5:0]    len_q;
    logic [7:0]    wait_q;
    logic          auth_q;
    logic [7:0]    fail_q;
    logic [7:0]    rom_data;
    logic [8:0]    limit;
    logic [7:0]    ver_byte;
    logic          cmd_done;
    logic          match;
    logic [31:0]   pwd_q;

    ntresp_sig_rom #(
        .DEPTH (ntresp_pkg::SIG_LEN),
        .INIT  (SIGNATURE)
    ) u_rom (
        .clk   (clk),
        .rstn  (rstn),
        .addr  (idx_q[4:0]),
        .rdata (rom_data)
    );

    // Limit threshold 2^field; zero field means no limit
    assign limit    = 9'h001 << attempt_limit_field;
    assign locked_out = (attempt_limit_field != 3'h0) && ({1'b0, fail_q} >= limit); // R15
    // Compare the four password bytes, never the trailing check bytes
    assign match    = (pwd_q == password);
    assign cmd_done = rx_valid && rx_last;

    // Version byte table
    always_comb begin
        case (idx_q[2:0])
            3'd0:    ver_byte = ntresp_pkg::VER_HEADER; // R5
            3'd1:    ver_byte = VENDOR_ID;
            3'd2:    ver_byte = PROD_TYPE;
            3'd3:    ver_byte = PROD_SUB;
            3'd4:    ver_byte = VER_MAJOR;
            3'd5:    ver_byte = VER_MINOR;
            3'd6:    ver_byte = SIZE_CODE; // R6 R7
            default: ver_byte = ntresp_pkg::VER_PROTOCOL; // R5
        endcase
    end

    // Command sequencing: collect frame, hold off frame delay, stream answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= NR_IDLE;
            ans_q     <= AN_NAK;
            cmd_q     <= 8'h00;
            arg_cnt_q <= 3'h0;
            arg_q     <= 32'h0;
            nak_q     <= 4'h0;
            len_q     <= 6'h0;
            wait_q    <= 8'h00;
        end else begin
            case (state_q)
                NR_IDLE: begin
                    arg_cnt_q <= 3'h0;
                    if (sel_cl2_ok) begin
                        ans_q   <= AN_SAK; // R2
                        len_q   <= 6'd1;
                        wait_q  <= 8'h00;
                        state_q <= NR_WAIT;
                    end else if (rx_valid) begin
                        cmd_q   <= rx_byte;
                        state_q <= NR_RECV;
                        if (rx_last) begin
                            state_q <= NR_WAIT;
                            wait_q  <= 8'h00;
                            len_q   <= 6'd1;
                            if (rx_byte == ntresp_pkg::CMD_REQA || rx_byte == ntresp_pkg::CMD_WUPA) begin
                                ans_q <= AN_ATQA; // R1
                                len_q <= 6'(ntresp_pkg::ATQA_LEN);
                            end else begin
                                ans_q <= AN_NAK;
                                nak_q <= rx_crc_err ? ntresp_pkg::NAK_CRC : ntresp_pkg::NAK_INVALID; // R19
                            end
                        end
                    end
                end
                NR_RECV: begin
                    if (rx_valid) begin
                        arg_q     <= {arg_q[23:0], rx_byte};
                        arg_cnt_q <= arg_cnt_q + 3'h1;
                    end
                    if (cmd_done) begin
                        state_q <= NR_WAIT;
                        wait_q  <= 8'h00;
                        len_q   <= 6'd1;
                        ans_q   <= AN_NAK;
                        nak_q   <= ntresp_pkg::NAK_INVALID; // R17
                        if (rx_crc_err) begin
                            nak_q <= ntresp_pkg::NAK_CRC; // R19
                        end else if (cmd_q == ntresp_pkg::CMD_VERSION) begin
                            // Frame counts CRC bytes only: two trailing bytes
                            if (arg_cnt_q == 3'd1) begin
                                ans_q <= AN_VER; // R4
                                len_q <= 6'(ntresp_pkg::VER_LEN);
                            end
                        end else if (cmd_q == ntresp_pkg::CMD_SIG) begin
                            if (arg_cnt_q == 3'd2 && arg_q[15:8] == ntresp_pkg::SIG_ADDR) begin
                                ans_q <= AN_SIG; // R8
                                len_q <= 6'(ntresp_pkg::SIG_LEN);
                            end
                        end else if (cmd_q == ntresp_pkg::CMD_PWD && arg_cnt_q == 3'd5) begin
                            if (locked_out) begin
                                nak_q <= ntresp_pkg::NAK_LIMIT; // R18
                            end else if (match) begin
                                ans_q <= AN_AUTH_ACK_VALUE; // R10
                                len_q <= 6'(ntresp_pkg::AUTH_ACK_VALUE_LEN);
                            end
                        end
                    end
                end
                NR_WAIT: begin
                    // Hold off the reply for the minimum frame delay
                    wait_q <= wait_q + 8'h01;
                    if (int'(wait_q) >= ntresp_pkg::FDT_CYC) begin
                        state_q <= NR_SEND; // R16
                    end
                end
                NR_SEND: begin
                    // Leave only once the last byte is really taken; signature bytes have gaps
                    if (tx_ready && tx_valid && tx_last) begin
                        state_q <= NR_DRAIN;
                    end
                end
                NR_DRAIN: begin
                    state_q <= NR_IDLE;
                end
                default: begin
                    state_q <= NR_IDLE;
                end
            endcase
        end
    end

    // Password argument capture keeps 4 password bytes: shifting stops after four argument bytes, so the CRC never enters
    // (arg_q holds last four received bytes; for 1Bh those are pwd[1:0] and CRC, so keep a copy)
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwd_q <= 32'h0;
        end else if (state_q == NR_RECV && rx_valid && arg_cnt_q < 3'd4) begin
            pwd_q <= {pwd_q[23:0], rx_byte};
        end
    end

    // Byte index into the answer; advanced as each byte is taken
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_q <= 6'h0;
        end else if (state_q != NR_SEND) begin
            idx_q <= 6'h0;
        end else if (tx_ready && tx_valid) begin
            idx_q <= idx_q + 6'h1;
        end
    end

    // Answer data; signature comes one cycle late from the store, so hold valid a cycle
    logic sig_lag_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sig_lag_q <= 1'b0;
        end else begin
            sig_lag_q <= (state_q == NR_SEND) && !(tx_ready && tx_valid);
        end
    end

    always_comb begin
        tx_valid = (state_q == NR_SEND) && (ans_q != AN_SIG || sig_lag_q);
        tx_last  = (idx_q == len_q - 6'h1);
        tx_nak   = (ans_q == AN_NAK);
        case (ans_q)
            AN_ATQA: tx_byte = idx_q[0] ? ntresp_pkg::ATQA_VALUE[15:8] : ntresp_pkg::ATQA_VALUE[7:0]; // R1 R3
            AN_SAK:  tx_byte = ntresp_pkg::SAK_VALUE; // R2
            AN_VER:  tx_byte = ver_byte; // R4
            AN_SIG:  tx_byte = rom_data; // R8
            AN_AUTH_ACK_VALUE: tx_byte = idx_q[0] ? auth_ack_value[7:0] : auth_ack_value[15:8]; // R10
            default: tx_byte = {4'h0, nak_q}; // R17
        endcase
    end

    // Session authentication and failure count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            auth_q <= 1'b0;
            fail_q <= 8'h00;
        end else if (halt || field_lost) begin
            auth_q <= 1'b0; // R20
        end else if (state_q == NR_RECV && cmd_done && !rx_crc_err
                     && cmd_q == ntresp_pkg::CMD_PWD && arg_cnt_q == 3'd5 && !locked_out) begin
            if (match) begin
                auth_q <= 1'b1; // R11
            end else begin
                auth_q <= 1'b0;
                if (attempt_limit_field != 3'h0 && fail_q != 8'hFF) begin
                    fail_q <= fail_q + 8'h01; // R14
                end
            end
        end
    end

    // Page access decision for the memory side
    always_comb begin
        page_protected = (page_addr >= protect_start_page); // R12
        write_allowed  = !page_protected || (auth_q && !locked_out); // R11 R15
        read_allowed   = !page_protected || !protect_level_bit || (auth_q && !locked_out); // R13
    end

    assign authenticated = auth_q;
    assign fail_count    = fail_q;
endmodule

/* File: tb/ntresp_checker.sv */
`timescale 1ns/100ps
// Port watch: answer delay, held hand-off and page gating
module ntresp_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       rx_valid,
    input wire logic       rx_last,
    input wire logic       halt,
    input wire logic       field_lost,
    input wire logic       tx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_nak,
    input wire logic       authenticated,
    input wire logic       locked_out,
    input wire logic       page_protected,
    input wire logic       protect_level_bit,
    input wire logic       read_allowed,
    input wire logic       write_allowed
);
    logic        mid_q;
    logic [15:0] quiet_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Activation frames are one byte with their own timing, so only longer frames load the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mid_q   <= 1'b0;
            quiet_q <= 16'h0000;
        end else begin
            if (rx_valid) mid_q <= !rx_last;
            if (rx_valid && rx_last && mid_q) quiet_q <= 16'(ntresp_pkg::FDT_CYC);
            else if (quiet_q != 16'h0000) quiet_q <= quiet_q - 16'h0001;
        end
    end
    property p_quiet; quiet_q != 16'h0000 |-> !tx_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer inside frame delay");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_nak); endproperty
    a_hold: assert property (p_hold) else $error("answer changed before taken");
    property p_limnak; tx_valid && tx_nak && tx_byte[3:0] == ntresp_pkg::NAK_LIMIT |-> locked_out; endproperty
    a_limnak: assert property (p_limnak) else $error("limit code while not locked");
    property p_clear; halt || field_lost |=> !authenticated; endproperty
    a_clear: assert property (p_clear) else $error("authentication kept");
    property p_open; !page_protected |-> read_allowed && write_allowed; endproperty
    a_open: assert property (p_open) else $error("open page refused");
    property p_wgate; page_protected && (!authenticated || locked_out) |-> !write_allowed; endproperty
    a_wgate: assert property (p_wgate) else $error("protected write allowed");
    property p_rgate;
        page_protected && protect_level_bit && (!authenticated || locked_out) |-> !read_allowed;
    endproperty
    a_rgate: assert property (p_rgate) else $error("protected read allowed");
    property p_ropen; page_protected && !protect_level_bit |-> read_allowed; endproperty
    a_ropen: assert property (p_ropen) else $error("write-only level blocks read");
endmodule
bind ntresp_core ntresp_checker u_chk (.clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_last(rx_last),
    .halt(halt), .field_lost(field_lost), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_nak(tx_nak), .authenticated(authenticated), .locked_out(locked_out), .page_protected(page_protected),
    .protect_level_bit(protect_level_bit), .read_allowed(read_allowed), .write_allowed(write_allowed));

/* File: tb/ntresp_reader.sv */
`timescale 1ns/100ps
// Reader model: one frame byte per cycle, answers taken with random stalls
module ntresp_reader (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    input  wire logic       tx_nak,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_last,
    output logic            rx_crc_err,
    output logic            tx_ready
);
    logic [7:0] resp[$];
    logic       nak_q;
    logic       tmo;
    initial begin
        {rx_valid, rx_byte, rx_last, rx_crc_err, tx_ready} = 12'h000;
    end
    // Command, arguments and check bytes go out whole, then the lines are let go
    task automatic send(input logic [7:0] f[$], input logic bad);
        foreach (f[i]) begin
            @(posedge clk);
            #1 {rx_valid, rx_byte, rx_last, rx_crc_err} = {1'b1, f[i], i == f.size() - 1, bad};
        end
        @(posedge clk);
        #1 {rx_valid, rx_byte, rx_last, rx_crc_err} = {1'b0, ~rx_byte, 1'b0, ~bad}; // No stale value left
    endtask
    // Stalls at random so held answers get exercised; the bound stands in for the reader timeout
    task automatic collect();
        resp.delete();
        tmo = 1'b1;
        for (int n = 0; n < 20000 && tmo; n++) begin
            @(posedge clk);
            if (tx_valid && tx_ready) begin
                nak_q = tx_nak;
                resp.push_back(tx_byte);
                tmo = !tx_last;
            end
            #1 tx_ready = tmo && $urandom_range(3) != 0;
        end
    endtask
endmodule

/* File: tb/nfc_tag_ident_auth_responder_test.sv */
`timescale 1ns/100ps
// Reader traffic through activation, identity, signature and password paths
module nfc_tag_ident_auth_responder_test;
    localparam logic [255:0] SIG = {4{64'h0123456789ABCDEF}};
    logic        clk, rstn, sel_cl2_ok, halt, field_lost, protect_level_bit, rx_valid, rx_last, rx_crc_err;
    logic        tx_ready, tx_valid, tx_last, tx_nak, authenticated, locked_out, page_protected;
    logic        read_allowed, write_allowed;
    logic [7:0]  rx_byte, tx_byte, page_addr, protect_start_page, fail_count;
    logic [31:0] password;
    logic [15:0] auth_ack_value;
    logic [2:0]  attempt_limit_field;
    logic [7:0]  sig_q[$];
    int          miscompares, check_count, lim;
    // Identity parameters: arbitrary values chosen by the bench
    ntresp_core #(.VENDOR_ID(8'hA5), .PROD_TYPE(8'h5A), .PROD_SUB(8'h3C), .VER_MAJOR(8'h11), .VER_MINOR(8'h22),
        .LARGE_MEM(1'b0), .SIGNATURE(SIG)) u_dut (.clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_last(rx_last), .rx_crc_err(rx_crc_err), .sel_cl2_ok(sel_cl2_ok), .halt(halt), .field_lost(field_lost),
        .password(password), .auth_ack_value(auth_ack_value), .protect_start_page(protect_start_page),
        .protect_level_bit(protect_level_bit), .attempt_limit_field(attempt_limit_field), .page_addr(page_addr),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_nak(tx_nak),
        .authenticated(authenticated), .locked_out(locked_out), .page_protected(page_protected),
        .read_allowed(read_allowed), .write_allowed(write_allowed), .fail_count(fail_count));
    ntresp_reader u_rdr (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_nak(tx_nak),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_crc_err(rx_crc_err), .tx_ready(tx_ready));
    // Size code: n from the top seven bits, low bit set when not a power of two
    function automatic logic [7:0] size_code(input int bytes);
        int n;
        n = $clog2(bytes + 1) - 1;
        return {n[6:0], 1'(bytes != (1 << n))};
    endfunction
    task automatic results();
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Whole answer compared byte by byte; a negative answer only has four bits that count
    task automatic want(input logic [7:0] e[$], input logic nak);
        u_rdr.collect();
        if (u_rdr.tmo) begin
            miscompares++;
            results();
        end
        chk("answer_length", e.size(), u_rdr.resp.size());
        chk("answer_nak", nak, u_rdr.nak_q);
        foreach (e[i]) chk("answer_byte", e[i], nak ? {4'h0, u_rdr.resp[i][3:0]} : u_rdr.resp[i]);
    endtask
    task automatic xfer(input logic [7:0] f[$], input logic crc, input logic bad, input logic [7:0] e[$],
                        input logic nak);
        if (crc) begin
            f.push_back(8'($urandom()));
            f.push_back(8'($urandom()));
        end
        u_rdr.send(f, bad);
        want(e, nak);
    endtask
    task automatic pwd(input logic [31:0] p, input logic [7:0] e[$], input logic nak);
        xfer('{ntresp_pkg::CMD_PWD, p[31:24], p[23:16], p[15:8], p[7:0]}, 1'b1, 1'b0, e, nak);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1'b1;
        @(posedge clk);
        #1 s = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        miscompares = 0;
        check_count = 0;
        void'($urandom(32'h36FCF72D));
        {rstn, sel_cl2_ok, halt, field_lost, protect_level_bit, page_addr, attempt_limit_field} = 16'h0800;
        password = $urandom();
        auth_ack_value = 16'($urandom());
        protect_start_page = 8'h20;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        for (int i = 0; i < 2; i++) begin
            xfer('{i ? ntresp_pkg::CMD_WUPA : ntresp_pkg::CMD_REQA}, 1'b0, 1'b0, '{8'h44, 8'h00}, 1'b0);
            chk("uid_size_bits", 2'b01, u_rdr.resp[0][7:6]);
        end
        pulse(sel_cl2_ok);
        want('{8'h00}, 1'b0);
        // Identity bytes are the values handed to the instance above
        xfer('{ntresp_pkg::CMD_VERSION}, 1'b1, 1'b0, '{8'h00, 8'hA5, 8'h5A, 8'h3C, 8'h11, 8'h22, size_code(888),
            8'h03}, 1'b0);
        for (int i = 0; i < 32; i++) sig_q.push_back(SIG[8*i +: 8]);
        xfer('{ntresp_pkg::CMD_SIG, 8'h00}, 1'b1, 1'b0, sig_q, 1'b0);
        xfer('{ntresp_pkg::CMD_VERSION}, 1'b1, 1'b1, '{8'h01}, 1'b1);
        pwd(~password, '{8'h00}, 1'b1);
        chk("fail_count", 0, fail_count);
        pwd(password, '{auth_ack_value[15:8], auth_ack_value[7:0]}, 1'b0);
        page_addr = protect_start_page;
        @(negedge clk);
        chk("write_allowed", 1, write_allowed);
        pulse(halt);
        chk("authenticated", 0, authenticated);
        pwd(password, '{auth_ack_value[15:8], auth_ack_value[7:0]}, 1'b0);
        pulse(field_lost);
        chk("authenticated", 0, authenticated);
        repeat (24) begin
            @(posedge clk);
            #1 {page_addr, protect_start_page, protect_level_bit} = 17'($urandom());
            @(negedge clk);
            chk("page_protected", page_addr >= protect_start_page, page_protected);
            chk("read_allowed", !(page_addr >= protect_start_page && protect_level_bit), read_allowed);
            chk("write_allowed", page_addr < protect_start_page, write_allowed);
        end
        @(posedge clk);
        #1 protect_level_bit = 1'b1;
        page_addr = protect_start_page;
        lim = $urandom_range(2, 1);
        attempt_limit_field = 3'(lim);
        for (int i = 1; i <= (1 << lim); i++) begin
            pwd(password ^ (32'h1 << i), '{8'h00}, 1'b1);
            chk("fail_count", i, fail_count);
            chk("locked_out", i == (1 << lim), locked_out);
        end
        pwd(password, '{8'h04}, 1'b1);
        @(negedge clk);
        chk("authenticated", 0, authenticated);
        chk("write_allowed", 0, write_allowed);
        chk("read_allowed", 0, read_allowed);
        xfer('{ntresp_pkg::CMD_SIG, 8'h00}, 1'b1, 1'b0, sig_q, 1'b0);
        results();
    end
endmodule
